// ---- rtl/mfpc_consts.svh ----
// constants of the multifunction preset counter: timing, indices, values
// assumes the includer runs on the 100 MHz system clock
`ifndef MFPC_CONSTS_SVH
`define MFPC_CONSTS_SVH

`define MFPC_CLK_PERIOD_NS 10
// least settle time of a debounced input
`define MFPC_DEB_TIME_NS 100
`define MFPC_DEB_CYCLES \
   ((`MFPC_DEB_TIME_NS + `MFPC_CLK_PERIOD_NS - 1) / `MFPC_CLK_PERIOD_NS)
// tachometer gate window
`define MFPC_GATE_TIME_NS 1000000000
`define MFPC_GATE_CYCLES (`MFPC_GATE_TIME_NS / `MFPC_CLK_PERIOD_NS)

// value loaded on reset in increment or up/down direction
`define MFPC_PV_ZERO 0

// positions in the debounced input vector
`define MFPC_IN_CNT_A 0
`define MFPC_IN_CNT_B 1
`define MFPC_IN_RST1 2
`define MFPC_IN_RST2 3
`define MFPC_IN_KPROT 4
`define MFPC_IN_KEY_MODE 5
`define MFPC_IN_KEY_RESET 6
`define MFPC_IN_KEY_UP 7
`define MFPC_IN_COUNT 8

// key positions in the key vector
`define MFPC_KEY_MODE 0
`define MFPC_KEY_RESET 1
`define MFPC_KEY_UP 2
`define MFPC_KEY_COUNT 3

`endif

// ---- rtl/mfpc_pkg.sv ----
// types of the multifunction preset counter
// assumes the consts header carries every number
package mfpc_pkg;

   typedef enum logic [2:0] {
      MFPC_PRESET = 3'b000,
      MFPC_TOTAL  = 3'b001,
      MFPC_BATCH  = 3'b010,
      MFPC_DUAL   = 3'b011,
      MFPC_TWIN   = 3'b100,
      MFPC_TACHO  = 3'b101
   } mfpc_mode_t;

   typedef enum logic [1:0] {
      MFPC_DIR_INC = 2'b00,
      MFPC_DIR_DEC = 2'b01,
      MFPC_DIR_UD  = 2'b10
   } mfpc_dir_t;

   typedef enum logic [1:0] {
      MFPC_UD_CMD   = 2'b00,
      MFPC_UD_INDIV = 2'b01,
      MFPC_UD_QUAD  = 2'b10
   } mfpc_ud_t;

   typedef enum logic [1:0] {
      MFPC_TIN_SINGLE = 2'b00,
      MFPC_TIN_INDEP  = 2'b01,
      MFPC_TIN_OTHER  = 2'b10
   } mfpc_tin_t;

   typedef struct packed {
      mfpc_mode_t mode;
      mfpc_dir_t dir;
      mfpc_ud_t ud;
      logic two_stage;
      logic out_follow;
      mfpc_tin_t tach_in;
      logic [1:0] key_level;
      logic show_b;
   } mfpc_cfg_t;

endpackage

// ---- rtl/mfpc_counter.sv ----
// counting and measuring core of the multifunction preset counter
// assumes field pins are asynchronous, configuration is quasi-static
`include "mfpc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module mfpc_counter #(
   parameter int W = 20,
   parameter int DEB_CYCLES = `MFPC_DEB_CYCLES,
   parameter int unsigned GATE_CYCLES = `MFPC_GATE_CYCLES
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_I,
   // field pins
   input wire logic COUNT_INPUT_A_I,
   input wire logic COUNT_INPUT_B_I,
   input wire logic RESET1_PIN_I,
   input wire logic RESET2_PIN_I,
   input wire logic KEYPROT_PIN_I,
   input wire logic [`MFPC_KEY_COUNT-1:0] KEYS_I,
   // configuration
   input wire mfpc_pkg::mfpc_cfg_t CFG_I,
   input wire logic [W-1:0] SET_A_I,
   input wire logic [W-1:0] SET_B_I,
   // outputs
   output logic COMPARE_OUTPUT_A_O,
   output logic COMPARE_OUTPUT_B_O,
   output logic RESET_IND_O,
   output logic KEYPROT_IND_O,
   output logic [`MFPC_KEY_COUNT-1:0] KEYS_O,
   output logic [W-1:0] VALUE_A_O,
   output logic [W-1:0] VALUE_B_O
);

   localparam int N = `MFPC_IN_COUNT;
   localparam logic [W-1:0] ONE = W'(1);
   localparam logic [W-1:0] ZERO = W'(`MFPC_PV_ZERO);
   localparam logic [15:0] DEB_LAST = 16'(DEB_CYCLES - 1);

   // step request from the configured signalling, {up, down}
   function automatic logic [1:0] step_of(
      input mfpc_pkg::mfpc_dir_t dir,
      input mfpc_pkg::mfpc_ud_t ud,
      input logic rise_a,
      input logic rise_b,
      input logic edge_a,
      input logic lvl_a,
      input logic lvl_b);
      logic [1:0] s;
      s = 2'b00;
      case (dir)
         mfpc_pkg::MFPC_DIR_INC: s = {rise_a, 1'b0};
         mfpc_pkg::MFPC_DIR_DEC: s = {1'b0, rise_a};
         mfpc_pkg::MFPC_DIR_UD: begin
            case (ud)
               mfpc_pkg::MFPC_UD_CMD: s = {rise_a & ~lvl_b, rise_a & lvl_b};
               mfpc_pkg::MFPC_UD_INDIV: s = {rise_a & ~rise_b, rise_b & ~rise_a};
               mfpc_pkg::MFPC_UD_QUAD:
                  s = {edge_a & (lvl_a ^ lvl_b), edge_a & ~(lvl_a ^ lvl_b)};
               default: s = 2'b00;
            endcase
         end
         default: s = 2'b00;
      endcase
      return s;
   endfunction

   // set value reached, counting towards zero when decrementing
   function automatic logic hit(
      input logic [W-1:0] pv,
      input logic [W-1:0] sv,
      input logic [W-1:0] load,
      input logic dec);
      return dec ? (pv <= load - sv) : (pv >= sv);
   endfunction

   // keys blocked at each protection level
   function automatic logic [`MFPC_KEY_COUNT-1:0] key_mask(
      input logic [1:0] level);
      logic [`MFPC_KEY_COUNT-1:0] m;
      m = '0;
      case (level)
         2'h0: m[`MFPC_KEY_UP] = 1'b1;
         2'h1: m[`MFPC_KEY_RESET] = 1'b1;
         2'h2: m[`MFPC_KEY_RESET:`MFPC_KEY_MODE] = 2'h3;
         default: m = '1;
      endcase
      return m;
   endfunction

   logic [N-1:0] raw;
   logic [N-1:0] meta_ff, sync_ff;
   logic [N-1:0] deb_ff, deb_d_ff;
   logic [15:0] deb_cnt_ff [N];
   logic [N-1:0] rise;
   logic [N-1:0] edge_any;
   logic rst1, rst2, kprot, rst2_tach, hold, dec;
   logic [`MFPC_KEY_COUNT-1:0] key_ok;
   logic [1:0] step;
   logic [W-1:0] load;
   logic [W-1:0] pv_a_ff, pv_b_ff;
   logic [W-1:0] cnt_a_ff, cnt_b_ff;
   logic [W-1:0] meas_a_ff, meas_b_ff;
   logic [31:0] gate_cnt_ff;
   logic gate_end;
   logic reach_a, reach_b, reach_b_d_ff;
   logic clr_a, clr_b;
   mfpc_pkg::mfpc_mode_t mode;
   logic single_ch, split_ch;

   assign raw = {KEYS_I, KEYPROT_PIN_I, RESET2_PIN_I, RESET1_PIN_I,
                 COUNT_INPUT_B_I, COUNT_INPUT_A_I};
   assign mode = CFG_I.mode;
   assign split_ch = (mode == mfpc_pkg::MFPC_DUAL) ||
                     (mode == mfpc_pkg::MFPC_TWIN);
   assign single_ch = (mode == mfpc_pkg::MFPC_PRESET) ||
                      (mode == mfpc_pkg::MFPC_TOTAL) ||
                      (mode == mfpc_pkg::MFPC_BATCH);

   // two-stage synchroniser
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= raw;
         sync_ff <= meta_ff;
      end
   end

   // debounce: level must stand for DEB_CYCLES before it is taken
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         deb_ff <= '0;
         deb_d_ff <= '0;
         deb_cnt_ff <= '{default: 16'h0000};
      end else begin
         deb_d_ff <= deb_ff;
         for (int i = 0; i < N; i++) begin
            if (sync_ff[i] == deb_ff[i]) begin
               deb_cnt_ff[i] <= 16'h0000;
            end else if (deb_cnt_ff[i] >= DEB_LAST) begin
               deb_ff[i] <= sync_ff[i];
               deb_cnt_ff[i] <= 16'h0000;
            end else begin
               deb_cnt_ff[i] <= deb_cnt_ff[i] + 16'h0001;
            end
         end
      end
   end

   assign rise = deb_ff & ~deb_d_ff;
   assign edge_any = deb_ff ^ deb_d_ff;
   assign rst1 = deb_ff[`MFPC_IN_RST1];
   assign rst2 = deb_ff[`MFPC_IN_RST2];
   assign kprot = deb_ff[`MFPC_IN_KPROT];
   assign key_ok = deb_ff[`MFPC_IN_KEY_UP:`MFPC_IN_KEY_MODE] &
                   ~(kprot ? key_mask(CFG_I.key_level) : '0);

   assign dec = (CFG_I.dir == mfpc_pkg::MFPC_DIR_DEC);
   assign load = dec ? (CFG_I.two_stage ? SET_B_I : SET_A_I) : ZERO;
   assign step = step_of(CFG_I.dir, CFG_I.ud, rise[`MFPC_IN_CNT_A],
                         rise[`MFPC_IN_CNT_B], edge_any[`MFPC_IN_CNT_A],
                         deb_ff[`MFPC_IN_CNT_A],
                         deb_ff[`MFPC_IN_CNT_B]);

   // tachometer hold sources
   assign rst2_tach = rst2 && (CFG_I.tach_in == mfpc_pkg::MFPC_TIN_INDEP);
   assign hold = rst1 || rst2_tach || key_ok[`MFPC_KEY_RESET];

   // present value a
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         pv_a_ff <= '0;
      end else if (single_ch) begin
         if (rst1) begin
            pv_a_ff <= load;
         end else if (step[1]) begin
            pv_a_ff <= pv_a_ff + ONE;
         end else if (step[0]) begin
            pv_a_ff <= pv_a_ff - ONE;
         end
      end else if (split_ch) begin
         if (rst1) begin
            pv_a_ff <= ZERO;
         end else if (clr_a) begin
            pv_a_ff <= ZERO;
         end else if (rise[`MFPC_IN_CNT_A]) begin
            pv_a_ff <= pv_a_ff + ONE;
         end
      end
   end

   // present value b: total, batch or second channel
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         pv_b_ff <= '0;
      end else begin
         case (mode)
            mfpc_pkg::MFPC_TOTAL: begin
               if (rst2) begin
                  pv_b_ff <= ZERO;
               end else if (!rst1 && (step[1] || step[0])) begin
                  pv_b_ff <= pv_b_ff + ONE;
               end
            end
            mfpc_pkg::MFPC_BATCH: begin
               if (rst2) begin
                  pv_b_ff <= ZERO;
               end else if (reach_b && !reach_b_d_ff) begin
                  pv_b_ff <= pv_b_ff + ONE;
               end
            end
            mfpc_pkg::MFPC_DUAL: begin
               if (rst2) begin
                  pv_b_ff <= ZERO;
               end else if (rise[`MFPC_IN_CNT_B]) begin
                  pv_b_ff <= pv_b_ff + ONE;
               end
            end
            mfpc_pkg::MFPC_TWIN: begin
               if (rst2 && CFG_I.show_b) begin
                  pv_b_ff <= ZERO;
               end else if (rise[`MFPC_IN_CNT_B]) begin
                  pv_b_ff <= pv_b_ff + ONE;
               end
            end
            default: pv_b_ff <= pv_b_ff;
         endcase
      end
   end

   // tachometer: pulses per gate window
   assign gate_end = (gate_cnt_ff == GATE_CYCLES - 1);

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I || mode != mfpc_pkg::MFPC_TACHO || gate_end) begin
         gate_cnt_ff <= 32'h0000_0000;
         cnt_a_ff <= '0;
         cnt_b_ff <= '0;
      end else begin
         gate_cnt_ff <= gate_cnt_ff + 32'h0000_0001;
         if (rise[`MFPC_IN_CNT_A]) begin
            cnt_a_ff <= cnt_a_ff + ONE;
         end
         if (rise[`MFPC_IN_CNT_B] &&
             CFG_I.tach_in != mfpc_pkg::MFPC_TIN_SINGLE) begin
            cnt_b_ff <= cnt_b_ff + ONE;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         meas_a_ff <= '0;
         meas_b_ff <= '0;
      end else if (mode == mfpc_pkg::MFPC_TACHO && gate_end && !hold) begin
         meas_a_ff <= cnt_a_ff;
         meas_b_ff <= cnt_b_ff;
      end
   end

   // set values reached
   always_comb begin
      reach_a = 1'b0;
      reach_b = 1'b0;
      case (mode)
         mfpc_pkg::MFPC_PRESET,
         mfpc_pkg::MFPC_TOTAL: begin
            reach_a = hit(pv_a_ff, SET_A_I, load, dec);
            reach_b = hit(pv_a_ff, SET_B_I, load, dec);
         end
         mfpc_pkg::MFPC_BATCH: begin
            reach_a = pv_b_ff >= SET_A_I;
            reach_b = pv_a_ff >= SET_B_I;
         end
         mfpc_pkg::MFPC_DUAL,
         mfpc_pkg::MFPC_TWIN: begin
            reach_a = pv_a_ff >= SET_A_I;
            reach_b = pv_b_ff >= SET_B_I;
         end
         mfpc_pkg::MFPC_TACHO: begin
            reach_a = meas_a_ff >= SET_A_I;
            reach_b = (CFG_I.tach_in == mfpc_pkg::MFPC_TIN_INDEP) ?
                      (meas_b_ff >= SET_B_I) : (meas_a_ff >= SET_B_I);
         end
         default: reach_b = 1'b0;
      endcase
   end

   // output clears per mode
   assign clr_a = (mode == mfpc_pkg::MFPC_PRESET && rst1) ||
                  (mode == mfpc_pkg::MFPC_TOTAL && rst1) ||
                  (mode == mfpc_pkg::MFPC_BATCH && rst2) ||
                  (mode == mfpc_pkg::MFPC_DUAL && rst1) ||
                  (mode == mfpc_pkg::MFPC_TWIN &&
                   (rst1 || (rst2 && !CFG_I.show_b)));
   assign clr_b = (single_ch && rst1) ||
                  (mode == mfpc_pkg::MFPC_DUAL && rst2) ||
                  (mode == mfpc_pkg::MFPC_TWIN && rst2 &&
                   CFG_I.show_b);

   // compare outputs: latched or following
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         COMPARE_OUTPUT_A_O <= 1'b0;
         COMPARE_OUTPUT_B_O <= 1'b0;
         reach_b_d_ff <= 1'b0;
      end else begin
         reach_b_d_ff <= reach_b;
         if (clr_a) begin
            COMPARE_OUTPUT_A_O <= 1'b0;
         end else if (!(mode == mfpc_pkg::MFPC_TACHO && hold)) begin
            COMPARE_OUTPUT_A_O <= CFG_I.out_follow ? reach_a :
                                  (COMPARE_OUTPUT_A_O | reach_a);
         end
         if (clr_b) begin
            COMPARE_OUTPUT_B_O <= 1'b0;
         end else if (!(mode == mfpc_pkg::MFPC_TACHO && hold)) begin
            COMPARE_OUTPUT_B_O <= CFG_I.out_follow ? reach_b :
                                  (COMPARE_OUTPUT_B_O | reach_b);
         end
      end
   end

   // indicators, gated keys and displayed values
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         RESET_IND_O <= 1'b0;
         KEYPROT_IND_O <= 1'b0;
         KEYS_O <= '0;
      end else begin
         RESET_IND_O <= (mode == mfpc_pkg::MFPC_TACHO) ? hold : rst1;
         KEYPROT_IND_O <= kprot;
         KEYS_O <= key_ok;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         VALUE_A_O <= '0;
         VALUE_B_O <= '0;
      end else if (mode == mfpc_pkg::MFPC_TACHO) begin
         VALUE_A_O <= meas_a_ff;
         VALUE_B_O <= meas_b_ff;
      end else begin
         VALUE_A_O <= pv_a_ff;
         VALUE_B_O <= pv_b_ff;
      end
   end

endmodule // mfpc_counter

`default_nettype wire

// ---- tb/mfpc_counter_assertions.sv ----
// output checker of the preset counter core, bound onto mfpc_counter
// assumes the configuration only changes while RESET_I is high
`include "mfpc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module mfpc_counter_assertions #(
   parameter int W = 20
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_I,
   // configuration
   input wire mfpc_pkg::mfpc_cfg_t CFG_I,
   input wire logic [W-1:0] SET_A_I,
   // outputs
   input wire logic COMPARE_OUTPUT_A_O,
   input wire logic RESET_IND_O,
   input wire logic KEYPROT_IND_O,
   input wire logic [`MFPC_KEY_COUNT-1:0] KEYS_O,
   input wire logic [W-1:0] VALUE_A_O,
   input wire logic [W-1:0] VALUE_B_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);

   logic single;
   logic tach;
   logic inc;
   logic [`MFPC_KEY_COUNT-1:0] kmask;
   assign single = CFG_I.mode < mfpc_pkg::MFPC_DUAL;
   assign tach = CFG_I.mode == mfpc_pkg::MFPC_TACHO;
   assign inc = CFG_I.dir == mfpc_pkg::MFPC_DIR_INC;
   always_comb begin
      case (CFG_I.key_level)
         2'h0: kmask = 3'h4;
         2'h1: kmask = 3'h2;
         2'h2: kmask = 3'h3;
         default: kmask = 3'h7;
      endcase
   end

   // indicator lit long enough for the value to have settled
   sequence s_held;
      RESET_IND_O [*3];
   endsequence

   chk_rst_zero: assert property (
      (!tach && CFG_I.dir != mfpc_pkg::MFPC_DIR_DEC) ##0 s_held
      |-> VALUE_A_O == '0) else $error("value not cleared by reset");
   chk_rst_hold: assert property (
      !tach ##0 s_held |=> $stable(VALUE_A_O))
      else $error("value moved under reset");
   chk_step_a: assert property (
      !tach && (!single || inc && CFG_I.mode != mfpc_pkg::MFPC_BATCH)
      && $changed(VALUE_A_O) |-> VALUE_A_O == $past(VALUE_A_O) + 1'b1
      || VALUE_A_O == '0) else $error("value a step not one");
   chk_step_b: assert property (
      (CFG_I.mode == mfpc_pkg::MFPC_TOTAL && inc || !single && !tach)
      && $changed(VALUE_B_O) |-> VALUE_B_O == $past(VALUE_B_O) + 1'b1
      || VALUE_B_O == '0) else $error("value b step not one");
   chk_follow_out: assert property (
      CFG_I.mode == mfpc_pkg::MFPC_DUAL && CFG_I.out_follow
      |-> COMPARE_OUTPUT_A_O == (VALUE_A_O >= SET_A_I)
      || RESET_IND_O && !COMPARE_OUTPUT_A_O)
      else $error("output a not following compare");
   chk_latch_out: assert property (
      CFG_I.mode == mfpc_pkg::MFPC_PRESET && inc && !CFG_I.out_follow
      && $fell(COMPARE_OUTPUT_A_O) |-> ##[0:2] VALUE_A_O == '0)
      else $error("latched output dropped without reset");
   chk_tach_hold: assert property (
      tach ##0 s_held |=> $stable(VALUE_A_O)
      && $stable(COMPARE_OUTPUT_A_O)) else $error("hold not frozen");
   chk_key_mask: assert property (
      KEYPROT_IND_O [*2] |-> (KEYS_O & kmask) == '0)
      else $error("protected key passed");
endmodule // mfpc_counter_assertions

bind mfpc_counter mfpc_counter_assertions #(.W(W)) u_chk (
   .SYS_CLK_I(SYS_CLK_I),
   .RESET_I(RESET_I),
   .CFG_I(CFG_I),
   .SET_A_I(SET_A_I),
   .COMPARE_OUTPUT_A_O(COMPARE_OUTPUT_A_O),
   .RESET_IND_O(RESET_IND_O),
   .KEYPROT_IND_O(KEYPROT_IND_O),
   .KEYS_O(KEYS_O),
   .VALUE_A_O(VALUE_A_O),
   .VALUE_B_O(VALUE_B_O)
);

`default_nettype wire

// ---- tb/mfpc_field_model.sv ----
// field model: two count contacts, optional bounce on contact a, pulse trains
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none

module mfpc_field_model #(
   parameter int PH = 8
) (
   input wire logic clk_i,
   output var logic cnt_a_o,
   output var logic cnt_b_o
);
   initial begin
      cnt_a_o = 1'b0;
      cnt_b_o = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // bounce is one glitch, shorter than the settle time
   task automatic step(input logic a, input logic b, input bit bnc);
      if (bnc) begin
         cnt_a_o = a;
         hold(1);
         cnt_a_o = ~a;
         hold(1);
      end
      cnt_a_o = a;
      cnt_b_o = b;
      hold(PH);
   endtask

   task automatic train(input int per, input int n);
      repeat (n) begin
         cnt_a_o = 1'b1;
         hold(per / 2);
         cnt_a_o = 1'b0;
         hold(per / 2);
      end
   endtask
endmodule // mfpc_field_model

`default_nettype wire

// ---- tb/multifunction_preset_counter_bench.sv ----
// self-checking bench of the preset counter core against an int model
// assumes the field model drives both count pins
`timescale 1ns/100ps
`default_nettype none

module multifunction_preset_counter_bench;
   localparam int W = 20;
   localparam int LAT = 16;
   localparam logic [1:0] SEQ [12] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h2,
      2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h1, 2'h0};
   localparam logic [2:0] KM [4] = '{3'h3, 3'h5, 3'h4, 3'h0};
   logic clk, rst, r1, r2, kp, oa, ob, ind, kpi, la, lb, xo, xb;
   logic [2:0] keys, ko;
   logic [W-1:0] seta, va, vb;
   wire logic ca, cb;
   mfpc_pkg::mfpc_cfg_t cfg;
   int fails, n_compared, pa, pb, d;

   mfpc_field_model fm (.clk_i(clk), .cnt_a_o(ca), .cnt_b_o(cb));
   mfpc_counter #(.DEB_CYCLES(2), .GATE_CYCLES(200)) DUT (
      .SYS_CLK_I(clk), .RESET_I(rst), .COUNT_INPUT_A_I(ca),
      .COUNT_INPUT_B_I(cb), .RESET1_PIN_I(r1), .RESET2_PIN_I(r2),
      .KEYPROT_PIN_I(kp), .KEYS_I(keys), .CFG_I(cfg), .SET_A_I(seta),
      .SET_B_I(20'h8), .COMPARE_OUTPUT_A_O(oa), .COMPARE_OUTPUT_B_O(ob),
      .RESET_IND_O(ind), .KEYPROT_IND_O(kpi), .KEYS_O(ko),
      .VALUE_A_O(va), .VALUE_B_O(vb));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [W-1:0] seen,
                      input logic [W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic start;
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      pa = 0;
      pb = 0;
      xo = 1'b0;
      xb = 1'b0;
      cyc(LAT);
   endtask

   task automatic move(input logic a, input logic b, input bit bnc);
      d = 0;
      if (cfg.dir == mfpc_pkg::MFPC_DIR_INC) d = a & ~la;
      else if (cfg.dir == mfpc_pkg::MFPC_DIR_DEC) d = (a & ~la) ? -1 : 0;
      else if (cfg.ud == mfpc_pkg::MFPC_UD_CMD) d = (a & ~la) ? (b ? -1 : 1) : 0;
      else if (cfg.ud == mfpc_pkg::MFPC_UD_INDIV) d = (a & ~la) - (b & ~lb);
      else if (a != la) d = (a != b) ? 1 : -1;
      if (cfg.mode >= mfpc_pkg::MFPC_DUAL) begin
         pa += a & ~la & ~r1;
         pb += b & ~lb & ~r2;
      end else if (!r1) begin
         pa += d;
         pb += cfg.mode == mfpc_pkg::MFPC_TOTAL && !r2 && d != 0;
      end
      la = a;
      lb = b;
      fm.step(a, b, bnc);
   endtask

   task automatic rst1(input logic v);
      r1 = v;
      if (v) pa = cfg.dir == mfpc_pkg::MFPC_DIR_DEC ? (cfg.two_stage ? 8 : seta) : 0;
      if (v) xo = 1'b0;
      if (v) xb = 1'b0;
      cyc(LAT);
      chk("reset_ind", ind, v);
   endtask

   task automatic rst2(input logic v);
      r2 = v;
      if (v && cfg.mode != mfpc_pkg::MFPC_PRESET) pb = 0;
      cyc(LAT);
      chk("reset2_ind", ind, r1);
   endtask

   task automatic verify;
      int e;
      cyc(LAT);
      e = cfg.mode >= mfpc_pkg::MFPC_DUAL ? pb : pa;
      xo |= pa >= seta;
      xb |= e >= 8;
      chk("value_a", va, pa[W-1:0]);
      if (cfg.mode != mfpc_pkg::MFPC_PRESET) chk("value_b", vb, pb[W-1:0]);
      if (cfg.dir == mfpc_pkg::MFPC_DIR_INC) chk("out_a", oa, cfg.out_follow ? pa >= seta : xo);
      if (cfg.dir == mfpc_pkg::MFPC_DIR_INC) chk("out_b", ob, cfg.out_follow ? e >= 8 : xb);
   endtask

   initial begin
      cyc(60000);
      fails++;
      tally_and_finish;
   end

   initial begin
      fails = 0;
      n_compared = 0;
      rst = 1'b1;
      r1 = 1'b0;
      r2 = 1'b0;
      kp = 1'b0;
      keys = 3'h0;
      cfg = '0;
      la = 1'b0;
      lb = 1'b0;
      d = $urandom(32'hc28a2088);
      seta = 20'h5 + 20'($urandom % 3);
      cfg.two_stage = 1'($urandom);
      start;
      // secondary reset held the whole count, bounce on every other rising edge
      rst2(1'b1);
      for (int i = 0; i < seta; i++) begin
         move(1'b1, 1'b0, 1'(i));
         move(1'b0, 1'b0, 1'b0);
         verify;
      end
      rst2(1'b0);
      rst1(1'b1);
      move(1'b1, 1'b0, 1'b0);
      move(1'b0, 1'b0, 1'b0);
      verify;
      rst1(1'b0);
      verify;
      cfg.dir = mfpc_pkg::MFPC_DIR_DEC;
      start;
      rst1(1'b1);
      rst1(1'b0);
      move(1'b1, 1'b0, 1'b1);
      move(1'b0, 1'b0, 1'b0);
      verify;
      cfg.dir = mfpc_pkg::MFPC_DIR_UD;
      for (int u = 0; u < 3; u++) begin
         cfg.ud = mfpc_pkg::mfpc_ud_t'(u);
         start;
         foreach (SEQ[i]) move(SEQ[i][1], SEQ[i][0], 1'b0);
         if (u == 1) move(1'b1, 1'b1, 1'b0);
         if (u == 1) move(1'b0, 1'b0, 1'b0);
         verify;
      end
      cfg.mode = mfpc_pkg::MFPC_TOTAL;
      cfg.dir = mfpc_pkg::MFPC_DIR_INC;
      start;
      for (int i = 0; i < 4; i++) begin
         if (i == 3) rst2(1'b1);
         move(1'b1, 1'b0, 1'b0);
         move(1'b0, 1'b0, 1'b0);
         verify;
      end
      rst2(1'b0);
      cfg.mode = mfpc_pkg::MFPC_DUAL;
      cfg.out_follow = 1'b1;
      start;
      repeat (seta) begin
         move(1'b1, 1'b0, 1'b0);
         move(1'b1, 1'b1, 1'b0);
         move(1'b0, 1'b1, 1'b0);
         move(1'b0, 1'b0, 1'b0);
      end
      verify;
      for (int j = 0; j < 2; j++) begin
         if (j == 0) rst1(1'b1);
         else rst2(1'b1);
         move(1'b1, 1'b1, 1'b0);
         move(1'b0, 1'b0, 1'b0);
         verify;
         rst1(1'b0);
         rst2(1'b0);
      end
      cfg.mode = mfpc_pkg::MFPC_TACHO;
      cfg.out_follow = 1'b0;
      start;
      fork
         fm.train(20, 30);
         begin
            cyc(500);
            r1 = 1'b1;
            cyc(300);
            chk("tach_hold", va, 20'ha);
            chk("hold_ind", ind, 1'b1);
            r1 = 1'b0;
         end
      join
      cyc(420);
      chk("tach_idle", va, 20'h0);
      for (int lv = 0; lv < 4; lv++) begin
         cfg.key_level = 2'(lv);
         kp = 1'b1;
         keys = 3'h7;
         cyc(LAT);
         chk("kprot_ind", kpi, 1'b1);
         chk("keys", ko, KM[lv]);
         chk("key_hold", ind, lv == 0);
         kp = 1'b0;
         keys = 3'h0;
         cyc(LAT);
      end
      tally_and_finish;
   end
endmodule // multifunction_preset_counter_bench

`default_nettype wire
